// ==== rtl/irtx_pkg.sv ====
// package of constants and types for the infrared remote frame transmitter
package irtx_pkg;

  // fixed timebase, independent of any core clock setting
  localparam int unsigned MCLK_HZ       = 40_000_000;
  localparam int unsigned TICK_HZ       = 4_000_000;
  localparam int unsigned TICK_DIV      = MCLK_HZ / TICK_HZ;
  localparam logic [3:0]  TICK_DIV_LAST = 4'(TICK_DIV - 1);

  // carrier
  localparam int unsigned CARRIER_HZ    = 38_000;
  localparam int unsigned CARRIER_TICKS = (TICK_HZ + CARRIER_HZ / 2) / CARRIER_HZ;
  localparam int unsigned CARRIER_HALF  = CARRIER_TICKS / 2;

  // frame times in microseconds
  localparam int unsigned START_US      = 2400;
  localparam int unsigned ONE_US        = 1200;
  localparam int unsigned ZERO_US       = 600;
  localparam int unsigned GAP_US        = 600;

  // times as whole carrier periods, nearest
  localparam int unsigned PER_NS        = 1_000_000_000 / CARRIER_HZ;
  localparam logic [7:0]  START_CYC     = 8'((START_US * 1000 + PER_NS / 2) / PER_NS);
  localparam logic [7:0]  ONE_CYC       = 8'((ONE_US * 1000 + PER_NS / 2) / PER_NS);
  localparam logic [7:0]  ZERO_CYC      = 8'((ZERO_US * 1000 + PER_NS / 2) / PER_NS);
  localparam logic [7:0]  GAP_CYC       = 8'((GAP_US * 1000 + PER_NS / 2) / PER_NS);

  // payload layout
  localparam int unsigned CMD_BITS      = 7;
  localparam int unsigned DEV_BITS      = 5;
  localparam int unsigned PAY_BITS      = CMD_BITS + DEV_BITS;
  localparam logic [3:0]  PAY_LAST      = 4'(PAY_BITS - 1);

  typedef enum logic [1:0] {IRTX_IDLE, IRTX_BURST, IRTX_GAP} irtx_state_t;

  // one transmit request
  typedef struct packed {
    logic [2:0] pin;
    logic [4:0] dev;
    logic [6:0] cmd;
  } irtx_req_t;

endpackage

// ==== rtl/irtx_carrier.sv ====
// carrier and 4 MHz tick generator
`timescale 1ns/100ps
module irtx_carrier
  import irtx_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // control
  input  wire logic run,
  // outputs
  output logic      carrier,
  output logic      period_end
);

  typedef struct packed {
    logic [3:0] div;
    logic [6:0] ph;
    logic       pend;
  } irtx_car_st_t;

  irtx_car_st_t st_r;
  irtx_car_st_t st_nxt;

  // phase restarts when idle so every burst starts on a whole period
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.pend = 1'b0;
    if (!run)
    begin
      st_nxt = '0;
    end
    else if (st_r.div == TICK_DIV_LAST)
    begin
      st_nxt.div = '0;
      if (st_r.ph == 7'(CARRIER_TICKS - 1))
      begin
        st_nxt.ph   = '0;
        st_nxt.pend = 1'b1;
      end
      else
      begin
        st_nxt.ph = st_r.ph + 7'd1;
      end
    end
    else
    begin
      st_nxt.div = st_r.div + 4'd1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // decoded from the phase so every high half spans all ten cycles of phase 0;
  // gated by run so the cycle that launches a frame stays dark
  assign carrier    = run && (st_r.ph < 7'(CARRIER_HALF));
  assign period_end = st_r.pend;

endmodule

// ==== rtl/irtx_top.sv ====
// infrared remote frame transmitter: start burst, 12 bits, gated 38 kHz carrier
`timescale 1ns/100ps
module irtx_top
  import irtx_pkg::*;
#(
  parameter int unsigned NUM_PINS = 8
)
(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rstn,
  // command
  input  wire logic                start,
  input  wire logic [2:0]          pin_sel,
  input  wire logic [7:0]          dev_id,
  input  wire logic [7:0]          cmd_code,
  // status
  output logic                     busy,
  output logic                     done,
  output logic                     rejected,
  // led outputs
  output logic [NUM_PINS-1:0]      led
);

  // frame walk, in carrier periods of 105 ticks:
  //   start edge    operands checked, busy raised, carrier restarted
  //   start burst   91 periods of carrier on the chosen pin
  //   gap           23 periods dark
  //   bit burst     46 periods for a one, 23 for a zero
  //   gap           23 periods dark after every bit
  //   after the twelfth bit's gap  busy drops, done pulses once
  // the carrier phase runs on through each gap, so a burst opens on
  // a period boundary and every burst holds whole periods only
  // led lags the carrier by one register stage; all bursts and gaps
  // see the same lag, so their lengths are kept exactly
  // burst lengths are rounded to whole periods, which trades a few
  // microseconds of length for clean carrier edges at burst ends
  // a start while busy is ignored; the sender owns repetition

  // elaboration checks: pin count fits the three-bit selector
  if (NUM_PINS < 1 || NUM_PINS > 8)
  begin : g_bad_pins
    $error("NUM_PINS must be 1 to 8");
  end

  // tick divider must fit its four-bit counter and divide exactly
  if (TICK_DIV < 1 || TICK_DIV > 16)
  begin : g_bad_div
    $error("tick divider out of range");
  end

  // an inexact divider would skew every burst
  if (TICK_DIV * TICK_HZ != MCLK_HZ)
  begin : g_bad_div_exact
    $error("clock is not a whole multiple of the tick");
  end

  // carrier phase counter is seven bits
  if (CARRIER_TICKS < 2 || CARRIER_TICKS > 128)
  begin : g_bad_carrier
    $error("carrier period out of range");
  end

  // high half must be shorter than the period
  if (CARRIER_HALF < 1 || CARRIER_HALF >= CARRIER_TICKS)
  begin : g_bad_half
    $error("carrier high half out of range");
  end

  // start period count must fit the eight-bit down counter
  if ((START_US * 1000 + PER_NS / 2) / PER_NS > 255)
  begin : g_bad_start
    $error("start burst count too large");
  end

  // the sequencer ends a phase at count one, so zero is unusable
  if (START_CYC == 8'h00 || ONE_CYC == 8'h00)
  begin : g_bad_long
    $error("burst count must not be zero");
  end

  // zero bursts and gaps have the same constraint
  if (ZERO_CYC == 8'h00 || GAP_CYC == 8'h00)
  begin : g_bad_short
    $error("short count must not be zero");
  end

  // a one must be told apart from a zero
  if (ONE_CYC <= ZERO_CYC)
  begin : g_bad_order
    $error("one burst must outlast zero burst");
  end

  // bit index counter is four bits
  if (PAY_BITS < 1 || PAY_BITS > 16)
  begin : g_bad_pay
    $error("payload length out of range");
  end

  // request fields are fixed at seven and five bits
  if (CMD_BITS != 7 || DEV_BITS != 5)
  begin : g_bad_fields
    $error("payload field widths do not match the request");
  end

  typedef struct packed {
    irtx_state_t         state;
    irtx_req_t           req;
    logic [3:0]          bit_idx;
    logic                in_start;
    logic [7:0]          cyc;
    logic                busy;
    logic                done;
    logic                rej;
    logic [NUM_PINS-1:0] led;
  } irtx_st_t;

  irtx_st_t st_r;
  irtx_st_t st_nxt;

  logic car_run;
  logic carrier;
  logic period_end;
  logic next_bit;
  logic [PAY_BITS-1:0] payload;

  // tick divider and carrier restart at each frame
  assign car_run = (st_r.state != IRTX_IDLE);

  irtx_carrier u_carrier (
    .mclk       (mclk),
    .rstn       (rstn),
    .run        (car_run),
    .carrier    (carrier),
    .period_end (period_end)
  );

  // identifier above command so index 0 is command lsb
  assign payload = {st_r.req.dev, st_r.req.cmd};

  // bit sent after the current gap; only read while a bit remains
  always_comb
  begin
    next_bit = payload[0];
    if (!st_r.in_start && st_r.bit_idx < PAY_LAST)
      next_bit = payload[st_r.bit_idx + 4'd1];
  end

  // frame sequencer, counted in whole carrier periods
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    st_nxt.rej  = 1'b0;
    case (st_r.state)
      IRTX_IDLE:
      begin
        if (start)
        begin
          // dev_id above 31 or cmd above 127 cannot be framed
          if (cmd_code[7] || (dev_id[7:5] != 3'h0)
              || (32'(pin_sel) >= NUM_PINS))
          begin
            st_nxt.rej = 1'b1;
          end
          else
          begin
            st_nxt.req.pin   = pin_sel;
            st_nxt.req.dev   = dev_id[4:0];
            st_nxt.req.cmd   = cmd_code[6:0];
            st_nxt.bit_idx   = '0;
            st_nxt.in_start  = 1'b1;
            st_nxt.cyc       = START_CYC;
            st_nxt.busy      = 1'b1;
            st_nxt.state     = IRTX_BURST;
          end
        end
      end
      IRTX_BURST:
      begin
        if (period_end)
        begin
          if (st_r.cyc == 8'h01)
          begin
            st_nxt.cyc   = GAP_CYC;
            st_nxt.state = IRTX_GAP;
          end
          else
          begin
            st_nxt.cyc = st_r.cyc - 8'h01;
          end
        end
      end
      IRTX_GAP:
      begin
        if (period_end)
        begin
          if (st_r.cyc != 8'h01)
          begin
            st_nxt.cyc = st_r.cyc - 8'h01;
          end
          else if (!st_r.in_start && st_r.bit_idx == PAY_LAST)
          begin
            st_nxt.busy  = 1'b0;
            st_nxt.done  = 1'b1;
            st_nxt.state = IRTX_IDLE;
          end
          else
          begin
            if (!st_r.in_start)
              st_nxt.bit_idx = st_r.bit_idx + 4'd1;
            st_nxt.in_start = 1'b0;
            st_nxt.state    = IRTX_BURST;
            // width of the next bit's burst
            if (next_bit)
              st_nxt.cyc = ONE_CYC;
            else
              st_nxt.cyc = ZERO_CYC;
          end
        end
      end
      default:
      begin
        st_nxt = '0;
      end
    endcase
    // led follows carrier only on the chosen pin during a burst
    st_nxt.led = '0;
    // gating on the next state keeps the first high half of a burst whole
    if (st_nxt.state == IRTX_BURST)
      st_nxt.led[st_nxt.req.pin] = carrier;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // every output straight from the state register
  assign busy     = st_r.busy;
  assign done     = st_r.done;
  assign rejected = st_r.rej;
  assign led      = st_r.led;

endmodule

// ==== test/irtx_checker.sv ====
// port assertions for the infrared frame transmitter
`timescale 1ns/100ps
module irtx_checker
  import irtx_pkg::*;
#(
  parameter int unsigned NUM_PINS = 8
)
(
  // clock and reset
  input wire logic                mclk,
  input wire logic                rstn,
  // command
  input wire logic                start,
  input wire logic [2:0]          pin_sel,
  input wire logic [7:0]          dev_id,
  input wire logic [7:0]          cmd_code,
  // status and led
  input wire logic                busy,
  input wire logic                done,
  input wire logic                rejected,
  input wire logic [NUM_PINS-1:0] led
);
  logic        ok_req;
  logic [15:0] hi_r;
  logic [15:0] lo_r;
  logic [9:0]  rise_r;
  logic [9:0]  want_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  assign ok_req = start && !busy && dev_id <= 8'h1f && cmd_code <= 8'h7f
                  && int'(pin_sel) < NUM_PINS;
  // phase lengths; low count saturates so long idle cannot wrap
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      lo_r <= 16'h0;
    else
      lo_r <= (|led) ? 16'h0 : lo_r + {15'h0, ~&lo_r};
    hi_r   <= (|led) ? hi_r + 16'h1 : 16'h0;
    rise_r <= ok_req ? 10'h0 : rise_r + 10'($rose(|led));
    if (ok_req)
      want_r <= 10'd91 + 10'd23 * (10'd12 + 10'($countones({dev_id[4:0], cmd_code[6:0]})));
  end
  sequence s_accept;
    ok_req ##1 busy;
  endsequence
  property p_accept; ok_req |=> busy && !rejected; endproperty
  property p_reject; start && !busy && (dev_id > 8'h1f || cmd_code > 8'h7f)
    |=> rejected && !busy; endproperty
  property p_idle; !busy |-> led == '0; endproperty
  property p_onehot; $onehot0(led); endproperty
  property p_done; done |-> !busy ##1 !done; endproperty
  property p_first; s_accept |-> ##[0:4] (|led); endproperty
  property p_high; $fell(|led) |-> hi_r == 16'd520; endproperty
  property p_low; $rose(|led) && rise_r != 10'h0 |-> lo_r == 16'd530 || lo_r == 16'd24680;
  endproperty
  property p_count; done |-> rise_r == want_r; endproperty
  a_accept: assert property (p_accept) else $error("accepted start gave no busy");
  a_reject: assert property (p_reject) else $error("bad operand not refused");
  a_idle: assert property (p_idle) else $error("led active while idle");
  a_onehot: assert property (p_onehot) else $error("more than one led pin");
  a_done: assert property (p_done) else $error("done not a lone pulse");
  a_first: assert property (p_first) else $error("start burst late");
  a_high: assert property (p_high) else $error("carrier high phase length");
  a_low: assert property (p_low) else $error("carrier low or gap length");
  a_count: assert property (p_count) else $error("carrier periods in frame");
endmodule
bind irtx_top irtx_checker #(.NUM_PINS(NUM_PINS)) irtx_checker_inst (.mclk(mclk),
  .rstn(rstn), .start(start), .pin_sel(pin_sel), .dev_id(dev_id), .cmd_code(cmd_code),
  .busy(busy), .done(done), .rejected(rejected), .led(led));

// ==== test/irtx_rx_model.sv ====
// receiver model: sorts bursts by carrier period count, lsb first
`timescale 1ns/100ps
module irtx_rx_model (
  // clock and watched led line
  input  wire logic   mclk,
  input  wire logic   line,
  // decoded frame
  output logic [11:0] word_r = 12'h0,
  output logic [4:0]  nbits_r = 5'h0,
  output logic        frame_ok_r = 1'b0
);
  logic        line_q = 1'b0;
  logic [7:0]  per_r = 8'h0;
  logic [15:0] quiet_r = 16'h0;
  // a burst ends after more than one quiet carrier period
  // each start burst restarts decoding, so repeated frames decode alike
  always @(posedge mclk)
  begin
    line_q <= line;
    quiet_r <= (line && !line_q) ? 16'h0 : quiet_r + {15'h0, ~&quiet_r};
    if (line && !line_q)
      per_r <= per_r + 8'h1;
    if (quiet_r == 16'd1200 && per_r != 8'h0)
    begin
      per_r <= 8'h0;
      frame_ok_r <= (per_r == 8'd91) || (frame_ok_r && (per_r == 8'd46 || per_r == 8'd23));
      nbits_r <= (per_r == 8'd91) ? 5'h0 : nbits_r + 5'h1;
      if (per_r != 8'd91)
        word_r <= {per_r == 8'd46, word_r[11:1]};
    end
  end
endmodule

// ==== test/irtx_top_tb.sv ====
// self-checking bench for the infrared frame transmitter
`timescale 1ns/100ps
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module irtx_top_tb;
  import irtx_pkg::*;
  logic        mclk;
  logic        rstn;
  logic        start;
  logic [2:0]  pin_sel;
  logic [7:0]  dev_id;
  logic [7:0]  cmd_code;
  logic        busy;
  logic        done;
  logic        rejected;
  logic [7:0]  led;
  logic [11:0] word;
  logic [4:0]  nbits;
  logic        frame_ok;
  int          failures = 0;
  int          comparisons = 0;
  int          cyc = 0;
  irtx_top #(.NUM_PINS(8)) irtx_top_inst (.mclk(mclk), .rstn(rstn), .start(start),
    .pin_sel(pin_sel), .dev_id(dev_id), .cmd_code(cmd_code), .busy(busy), .done(done),
    .rejected(rejected), .led(led));
  irtx_rx_model irtx_rx_model_inst (.mclk(mclk), .line(led[pin_sel]), .word_r(word),
    .nbits_r(nbits), .frame_ok_r(frame_ok));
  function automatic logic [11:0] exp_word(input logic [7:0] d, input logic [7:0] c);
    return {d[4:0], c[6:0]};
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one request; a good frame also gets an ignored start pulse mid-frame
  task automatic send(input logic [2:0] p, input logic [7:0] d, input logic [7:0] c,
                      input logic bad);
    int n;
    @(negedge mclk);
    start = 1'b1;
    pin_sel = p;
    dev_id = d;
    cmd_code = c;
    @(negedge mclk);
    start = 1'b0;
    `CHK(rejected, bad, "refusal")
    `CHK(busy, ~bad, "busy")
    if (!bad)
    begin
      repeat (200) @(negedge mclk);
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      `CHK(rejected, 1'b0, "start while busy")
      n = 0;
      while (done !== 1'b1 && n < 1100000)
      begin
        @(negedge mclk);
        n++;
      end
      `CHK(done, 1'b1, "frame end")
      `CHK(frame_ok, 1'b1, "burst lengths")
      `CHK(nbits, 5'd12, "bit count")
      `CHK(word, exp_word(d, c), "payload order")
    end
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // a full frame is near a million cycles, so the ceiling allows one
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 1200000)
    begin
      failures++;
      tally_and_finish;
    end
  end
  initial
  begin
    rstn = 1'b0;
    start = 1'b0;
    pin_sel = 3'h0;
    dev_id = 8'h0;
    cmd_code = 8'h0;
    void'($urandom(37398));
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    `CHK(led, 8'h00, "led after reset")
    send(3'($urandom), 8'h20, 8'h00, 1'b1);
    send(3'($urandom), 8'h00, 8'h80, 1'b1);
    send(3'($urandom), 8'hff, 8'hff, 1'b1);
    send(3'($urandom), 8'h01, 8'($urandom_range(127)), 1'b0);
    tally_and_finish;
  end
endmodule
